/* File: design/dsp_exec_pkg.sv */
package dsp_exec_pkg;
  // Register file shape
  localparam int REG_COUNT = 8;
  localparam int SEL_W = 3;
  localparam int INT_W = 32;
  localparam int EXP_W = 8;
  localparam int EXT_W = 40;
  localparam int ADDR_W = 24;
  localparam int SHIFT_W = 6;
  // Field positions inside an extended-precision word
  localparam int EXP_MSB = 39;
  localparam int EXP_LSB = 32;
  localparam int MANT_MSB = 31;
  // Float format constants
  localparam logic [EXP_W-1:0] EXP_OF_ZERO = 8'h80;
  localparam logic [EXP_W-1:0] EXP_BIAS_TOP = 8'h1e;
  // Highest legal trap vector
  localparam logic [4:0] TRAP_VEC_MAX = 5'h1b;
  // Reset values and program counter step
  localparam logic [ADDR_W-1:0] PC_RESET = 24'h000000;
  localparam logic [EXT_W-1:0] EXT_RESET = 40'h0000000000;
  localparam logic [INT_W-1:0] AUX_RESET = 32'h00000000;
  localparam logic [ADDR_W-1:0] PC_STEP = 24'h000001;

  // Instructions handled by this slice
  typedef enum logic [3:0] {
    OP_NOP,
    OP_FLOAT,
    OP_IRQ_ACK,
    OP_IDLE,
    OP_LOW_POWER_WAIT,
    OP_LOAD_EXPONENT_ONLY,
    OP_LOAD_FP_VALUE,
    OP_LOAD_FP_CONDITIONAL,
    OP_LOAD_FP_LOCKED,
    OP_LOAD_INTEGER_VALUE,
    OP_TRAP
  } op_e;
endpackage

/* File: design/int_to_float.sv */
`timescale 1ns/1ps
`default_nettype none
module int_to_float
  import dsp_exec_pkg::*;
(
  input wire logic [INT_W-1:0] i_value,
  output logic [EXP_W-1:0] o_exp,
  output logic [INT_W-1:0] o_mant
);
  logic [SHIFT_W-1:0] k;
  logic done;
  logic [INT_W-1:0] shifted;

  // Count redundant sign bits, then normalise; implied bit is dropped
  always_comb begin
    k = '0;
    done = 1'b0;
    for (int i = INT_W - 2; i >= 0; i--) begin
      if (!done && i_value[i] == i_value[INT_W-1]) begin
        k = k + 6'h01;
      end else begin
        done = 1'b1;
      end
    end
    shifted = i_value << k;
    if (i_value == '0) begin
      o_exp = EXP_OF_ZERO;
      o_mant = '0;
    end else begin
      o_exp = EXP_BIAS_TOP - {2'h0, k};
      o_mant = {i_value[INT_W-1], shifted[INT_W-3:0], 1'b0};
    end
  end
endmodule
`default_nettype wire

/* File: design/dsp_load_idle_instr_exec.sv */
// Notes on behaviour
// - FLOAT converts the integer source and writes the selected extended register.
// - Interrupt acknowledge does a dummy read and pulses the strobe low then high.
// - Normal idle advances the program counter, then waits for an interrupt.
// - Low-power wait stops internal clocks until the next interrupt restarts execution.
// - Conditional fp load writes only when the condition is true.
// - Locked fp load signals an interlocked operation while loading.
// - Eight auxiliary registers, 0 to 7, selectable by instructions.
// - Eight extended-precision registers, 0 to 7, for loads and conversion.
// - Trap vectors 0 to 27 are accepted, others refused.
`timescale 1ns/1ps
`default_nettype none
module dsp_load_idle_instr_exec
  import dsp_exec_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_INSTR_VALID,
  input wire dsp_exec_pkg::op_e I_OPCODE,
  input wire logic [dsp_exec_pkg::SEL_W-1:0] I_DST,
  input wire logic I_DST_AUX,
  input wire logic [dsp_exec_pkg::EXT_W-1:0] I_SRC,
  input wire logic [dsp_exec_pkg::ADDR_W-1:0] I_SRC_ADDR,
  input wire logic I_COND_TRUE,
  input wire logic [4:0] I_TRAP_VEC,
  input wire logic I_IRQ_N,
  input wire logic [dsp_exec_pkg::SEL_W-1:0] I_RD_SEL,
  output logic O_READY,
  output logic [dsp_exec_pkg::ADDR_W-1:0] O_PC,
  output logic O_RD_STROBE,
  output logic [dsp_exec_pkg::ADDR_W-1:0] O_RD_ADDR,
  output logic O_IRQ_ACK_STROBE_N,
  output logic O_LOCK,
  output logic O_CLK_RUN,
  output logic O_TRAP_TAKEN,
  output logic O_TRAP_BAD,
  output logic [4:0] O_TRAP_VEC,
  output logic [dsp_exec_pkg::EXT_W-1:0] O_EXT_DATA,
  output logic [dsp_exec_pkg::INT_W-1:0] O_AUX_DATA
);
  import dsp_exec_pkg::*;

  typedef enum logic [1:0] {RUN, ACK_LOW, IDLE_WAIT, SLEEP} state_e;

  state_e state, next_state;
  logic [ADDR_W-1:0] pc, next_pc;
  logic [EXT_W-1:0] ext_prec_reg_n [REG_COUNT];
  logic [EXT_W-1:0] next_ext [REG_COUNT];
  logic [INT_W-1:0] aux_reg_n [REG_COUNT];
  logic [INT_W-1:0] next_aux [REG_COUNT];
  logic rd_strobe, next_rd_strobe;
  logic [ADDR_W-1:0] rd_addr, next_rd_addr;
  logic ack_n, next_ack_n;
  logic lock, next_lock;
  logic trap_taken, next_trap_taken;
  logic trap_bad, next_trap_bad;
  logic [4:0] trap_vec, next_trap_vec;
  logic [EXT_W-1:0] ext_data, next_ext_data;
  logic [INT_W-1:0] aux_data, next_aux_data;
  logic irq_meta, irq_sync;
  logic irq;
  logic accept;
  logic [EXP_W-1:0] conv_exp;
  logic [INT_W-1:0] conv_mant;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt pin crosses in through two flops; only irq_sync reads irq_meta
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      irq_meta <= 1'b1;
      irq_sync <= 1'b1;
    end else begin
      irq_meta <= I_IRQ_N;
      irq_sync <= irq_meta;
    end
  end
  assign irq = !irq_sync;

  // Converter for the integer-to-float instruction
  int_to_float u_conv (
    .i_value(I_SRC[INT_W-1:0]),
    .o_exp(conv_exp),
    .o_mant(conv_mant)
  );

  // Only the run state takes instructions
  assign accept = I_INSTR_VALID && (state == RUN);

  //////////////////////////////////////////////////////////////////////////
  // Next-state and datapath decisions
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_ext = ext_prec_reg_n;
    next_aux = aux_reg_n;
    next_rd_strobe = 1'b0;
    next_rd_addr = rd_addr;
    next_ack_n = 1'b1;
    next_lock = 1'b0;
    next_trap_taken = 1'b0;
    next_trap_bad = 1'b0;
    next_trap_vec = trap_vec;
    next_ext_data = ext_prec_reg_n[I_RD_SEL];
    next_aux_data = aux_reg_n[I_RD_SEL];
    unique case (state)
      RUN: begin
        if (accept) begin
          next_pc = pc + PC_STEP;
          unique case (I_OPCODE)
            OP_FLOAT: begin
              next_ext[I_DST] = {conv_exp, conv_mant};
            end
            OP_IRQ_ACK: begin
              // Dummy read and strobe low for one cycle
              next_rd_strobe = 1'b1;
              next_rd_addr = I_SRC_ADDR;
              next_ack_n = 1'b0;
              next_state = ACK_LOW;
            end
            OP_IDLE: begin
              next_state = IDLE_WAIT;
            end
            OP_LOW_POWER_WAIT: begin
              next_state = SLEEP;
            end
            OP_LOAD_EXPONENT_ONLY: begin
              // Mantissa is kept, only exponent bits replaced
              next_ext[I_DST][EXP_MSB:EXP_LSB] =
                I_SRC[EXP_MSB:EXP_LSB];
            end
            OP_LOAD_FP_VALUE: begin
              next_ext[I_DST] = I_SRC;
            end
            OP_LOAD_FP_CONDITIONAL: begin
              if (I_COND_TRUE) begin
                next_ext[I_DST] = I_SRC;
              end
            end
            OP_LOAD_FP_LOCKED: begin
              next_ext[I_DST] = I_SRC;
              next_lock = 1'b1;
            end
            OP_LOAD_INTEGER_VALUE: begin
              // Integer goes to an address register or a mantissa field
              if (I_DST_AUX) begin
                next_aux[I_DST] = I_SRC[INT_W-1:0];
              end else begin
                next_ext[I_DST][MANT_MSB:0] = I_SRC[INT_W-1:0];
              end
            end
            OP_TRAP: begin
              if (I_TRAP_VEC <= TRAP_VEC_MAX) begin
                next_trap_taken = 1'b1;
                next_trap_vec = I_TRAP_VEC;
              end else begin
                next_trap_bad = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ACK_LOW: begin
        next_state = RUN; // Strobe returns high here
      end
      IDLE_WAIT: begin
        if (irq) begin
          next_state = RUN;
        end
      end
      SLEEP: begin
        // The interrupt path and the register readback stay awake while clocks are stopped
        if (irq) begin
          next_state = RUN;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      state <= RUN;
      pc <= PC_RESET;
      for (int i = 0; i < REG_COUNT; i++) begin
        ext_prec_reg_n[i] <= EXT_RESET;
        aux_reg_n[i] <= AUX_RESET;
      end
      rd_strobe <= 1'b0;
      rd_addr <= '0;
      ack_n <= 1'b1;
      lock <= 1'b0;
      trap_taken <= 1'b0;
      trap_bad <= 1'b0;
      trap_vec <= '0;
      ext_data <= EXT_RESET;
      aux_data <= AUX_RESET;
    end else begin
      state <= next_state;
      pc <= next_pc;
      ext_prec_reg_n <= next_ext;
      aux_reg_n <= next_aux;
      rd_strobe <= next_rd_strobe;
      rd_addr <= next_rd_addr;
      ack_n <= next_ack_n;
      lock <= next_lock;
      trap_taken <= next_trap_taken;
      trap_bad <= next_trap_bad;
      trap_vec <= next_trap_vec;
      ext_data <= next_ext_data;
      aux_data <= next_aux_data;
    end
  end

  // Outputs
  assign O_READY = (state == RUN);
  assign O_PC = pc;
  assign O_RD_STROBE = rd_strobe;
  assign O_RD_ADDR = rd_addr;
  assign O_IRQ_ACK_STROBE_N = ack_n;
  assign O_LOCK = lock;
  assign O_CLK_RUN = (state != SLEEP); // Run enable for core clocks, low while asleep
  assign O_TRAP_TAKEN = trap_taken;
  assign O_TRAP_BAD = trap_bad;
  assign O_TRAP_VEC = trap_vec;
  assign O_EXT_DATA = ext_data;
  assign O_AUX_DATA = aux_data;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  AST_FLOAT_WRITE: assert property (
    accept && I_OPCODE == OP_FLOAT |=>
      ext_prec_reg_n[$past(I_DST)] == {$past(conv_exp), $past(conv_mant)})
    else $error("float result not written");
  AST_ACK_PULSE: assert property (
    accept && I_OPCODE == OP_IRQ_ACK |=>
      !O_IRQ_ACK_STROBE_N && O_RD_STROBE &&
      O_RD_ADDR == $past(I_SRC_ADDR) ##1 O_IRQ_ACK_STROBE_N)
    else $error("ack strobe or dummy read wrong");
  AST_IDLE_PC: assert property (
    accept && I_OPCODE == OP_IDLE |=>
      O_PC == $past(O_PC) + PC_STEP && state == IDLE_WAIT)
    else $error("idle did not step pc and wait");
  AST_IDLE_HOLD: assert property (
    state == IDLE_WAIT && !irq |=> state == IDLE_WAIT && !O_READY)
    else $error("idle left without interrupt");
  AST_SLEEP_CLK: assert property (
    accept && I_OPCODE == OP_LOW_POWER_WAIT |=>
      !O_CLK_RUN && !O_READY && O_PC == $past(O_PC) + PC_STEP)
    else $error("clocks not stopped");
  AST_SLEEP_WAKE: assert property (
    state == SLEEP && irq |=> O_CLK_RUN && O_READY)
    else $error("interrupt did not restart");
  AST_COND_FALSE: assert property (
    accept && I_OPCODE == OP_LOAD_FP_CONDITIONAL && !I_COND_TRUE |=>
      ext_prec_reg_n[$past(I_DST)] == $past(ext_prec_reg_n[I_DST]))
    else $error("conditional load changed register");
  AST_LOCK_LOAD: assert property (
    accept && I_OPCODE == OP_LOAD_FP_LOCKED |=>
      O_LOCK && ext_prec_reg_n[$past(I_DST)] == $past(I_SRC))
    else $error("locked load not signalled");
  AST_AUX_LOAD: assert property (
    accept && I_OPCODE == OP_LOAD_INTEGER_VALUE && I_DST_AUX |=>
      aux_reg_n[$past(I_DST)] == $past(I_SRC[INT_W-1:0]))
    else $error("aux register not loaded");
  AST_TRAP_RANGE: assert property (
    accept && I_OPCODE == OP_TRAP |=>
      (O_TRAP_TAKEN == ($past(I_TRAP_VEC) <= TRAP_VEC_MAX)) &&
      (O_TRAP_BAD != O_TRAP_TAKEN))
    else $error("trap vector range wrong");
  AST_EXP_ONLY: assert property (
    accept && I_OPCODE == OP_LOAD_EXPONENT_ONLY |=>
      ext_prec_reg_n[$past(I_DST)][MANT_MSB:0] ==
        $past(ext_prec_reg_n[I_DST][MANT_MSB:0]) &&
      ext_prec_reg_n[$past(I_DST)][EXP_MSB:EXP_LSB] ==
        $past(I_SRC[EXP_MSB:EXP_LSB]))
    else $error("exponent load disturbed mantissa");

  COV_ACK: cover property (accept && I_OPCODE == OP_IRQ_ACK ##2 O_READY);
  COV_SLEEP_WAKE: cover property (state == SLEEP ##[1:20] O_CLK_RUN);
  COV_IDLE_WAKE: cover property (state == IDLE_WAIT ##[1:20] O_READY);
  COV_COND_SKIP: cover property (
    accept && I_OPCODE == OP_LOAD_FP_CONDITIONAL && !I_COND_TRUE);
endmodule
`default_nettype wire

/* File: test/irq_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic [7:0] i_delay,
  input wire logic i_ack_n,
  output logic o_irq_n
);
  logic [7:0] cnt;
  logic armed;
  // Level request held until acknowledged, so a late ack keeps it pending
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt <= 8'h00;
      armed <= 1'b0;
      o_irq_n <= 1'b1;
    end else if (i_req) begin
      cnt <= i_delay;
      armed <= 1'b1;
    end else if (armed && cnt != 8'h00) begin
      cnt <= cnt - 8'h01; // Slow answer
    end else if (armed) begin
      armed <= 1'b0;
      o_irq_n <= 1'b0;
    end else if (!i_ack_n) begin
      o_irq_n <= 1'b1; // Released on the ack strobe
    end
  end
endmodule
`default_nettype wire

/* File: test/dsp_load_idle_instr_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dsp_load_idle_instr_exec_tb;
  import dsp_exec_pkg::*;
  typedef struct {logic aux; logic [EXT_W-1:0] v; int t;} note_s;
  logic clk, rstn, vld, daux, cond, irq_n, req;
  logic rdy, rds, ackn, lock, crun, ttk, tbad;
  op_e op;
  logic [SEL_W-1:0] dst, rsel;
  logic [EXT_W-1:0] src, xd, v;
  logic [ADDR_W-1:0] saddr, exp_pc, pc, raddr;
  logic [4:0] tvec, ovec, lastv;
  logic [7:0] dly;
  logic [INT_W-1:0] ad, w;
  logic [EXT_W-1:0] ext_m [REG_COUNT];
  logic [INT_W-1:0] aux_m [REG_COUNT];
  logic [31:0] seed;
  note_s q[$];
  note_s nt;
  int cyc, err_total, n_checks;
  dsp_load_idle_instr_exec dut_u (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_INSTR_VALID(vld), .I_OPCODE(op),
    .I_DST(dst), .I_DST_AUX(daux), .I_SRC(src), .I_SRC_ADDR(saddr),
    .I_COND_TRUE(cond), .I_TRAP_VEC(tvec), .I_IRQ_N(irq_n),
    .I_RD_SEL(rsel), .O_READY(rdy), .O_PC(pc), .O_RD_STROBE(rds),
    .O_RD_ADDR(raddr), .O_IRQ_ACK_STROBE_N(ackn), .O_LOCK(lock),
    .O_CLK_RUN(crun), .O_TRAP_TAKEN(ttk), .O_TRAP_BAD(tbad),
    .O_TRAP_VEC(ovec), .O_EXT_DATA(xd), .O_AUX_DATA(ad)
  );
  irq_source_model irq_u (
    .i_clk(clk), .i_rstn(rstn), .i_req(req), .i_delay(dly),
    .i_ack_n(ackn), .o_irq_n(irq_n)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock and cycle count used to time the notes
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Watchdog at 20000 cycles, far beyond the two hundred or so cycles the run needs
  initial begin
    #(100 * 20000);
    err_total++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected float of a non-negative integer, implied bit dropped
  function automatic logic [EXT_W-1:0] flt(input logic [INT_W-1:0] x);
    int p;
    logic [INT_W-1:0] m;
    if (x == 32'h00000000) return {EXP_OF_ZERO, 32'h00000000};
    p = 31;
    while (x[p] == 1'b0) p--;
    m = x << (31 - p);
    return {p[7:0], 1'b0, m[30:0]};
  endfunction
  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  // Valid is held high across calls, and every issue assigns it high again
  task automatic issue(input op_e o, input logic [SEL_W-1:0] d,
                       input logic [EXT_W-1:0] s, input bit acc);
    op = o;
    dst = d;
    src = s;
    vld = 1'b1;
    @(negedge clk);
    if (acc) exp_pc = exp_pc + PC_STEP;
    chk(pc === exp_pc, "program counter");
  endtask
  task automatic rd(input int r);
    vld = 1'b0;
    rsel = r[SEL_W-1:0];
    q.push_back('{1'b0, ext_m[r], cyc + 1});
    q.push_back('{1'b1, {8'h00, aux_m[r]}, cyc + 1});
    @(negedge clk);
  endtask
  task automatic rd_all();
    for (int r = 0; r < REG_COUNT; r++) rd(r);
  endtask
  task automatic wake(input logic [7:0] d);
    vld = 1'b0;
    dly = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    for (int i = 0; i < 300 && rdy !== 1'b1; i++) @(negedge clk);
    chk(rdy === 1'b1 && crun === 1'b1, "no wake");
  endtask
  task automatic ack();
    w = nxt();
    saddr = w[ADDR_W-1:0];
    issue(OP_IRQ_ACK, 3'h0, 40'h0000000000, 1'b1);
    chk(ackn === 1'b0 && rds === 1'b1 && raddr === saddr, "ack");
    issue(OP_NOP, 3'h0, 40'h0000000000, 1'b0);
    chk(ackn === 1'b1 && rdy === 1'b1 && rds === 1'b0, "ack end");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: takes due notes off the queue and compares
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].t == cyc) begin
      nt = q.pop_front();
      if (nt.aux) chk(ad === nt.v[INT_W-1:0], "aux readback");
      else chk(xd === nt.v, "ext readback");
    end
  end
  initial begin
    {rstn, vld, daux, cond, req} = 5'h00;
    op = OP_NOP;
    {dst, rsel, tvec, dly} = 19'h00000;
    src = 40'h0000000000;
    saddr = 24'h000000;
    {seed, cyc, err_total, n_checks} = {32'h2b2c, 96'h0};
    exp_pc = PC_RESET;
    for (int r = 0; r < REG_COUNT; r++) begin
      ext_m[r] = EXT_RESET;
      aux_m[r] = AUX_RESET;
    end
    // Count rising edges: the first clock step may look like a falling edge
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    chk(rdy === 1'b1 && ackn === 1'b1 && crun === 1'b1, "reset");
    rd_all();
    $display("test reset done");
    // Every load kind but the locked one on every register, back to back
    for (int r = 0; r < REG_COUNT; r++) begin
      w = nxt();
      v = {w[7:0], nxt()};
      ext_m[r] = v;
      issue(OP_LOAD_FP_VALUE, r[2:0], v, 1'b1);
      w = nxt();
      aux_m[r] = w;
      daux = 1'b1;
      issue(OP_LOAD_INTEGER_VALUE, r[2:0], {8'h5a, w}, 1'b1);
      w = nxt();
      ext_m[r][MANT_MSB:0] = w;
      daux = 1'b0;
      issue(OP_LOAD_INTEGER_VALUE, r[2:0], {8'ha5, w}, 1'b1);
      w = nxt();
      ext_m[r][EXP_MSB:EXP_LSB] = w[7:0];
      issue(OP_LOAD_EXPONENT_ONLY, r[2:0], {w[7:0], nxt()}, 1'b1);
      w = nxt();
      v = {w[15:8], nxt()};
      cond = w[0];
      if (w[0]) ext_m[r] = v;
      issue(OP_LOAD_FP_CONDITIONAL, r[2:0], v, 1'b1);
      cond = 1'b0;
    end
    w = nxt();
    v = {w[7:0], nxt()};
    ext_m[3] = v;
    issue(OP_LOAD_FP_LOCKED, 3'h3, v, 1'b1);
    chk(lock === 1'b1, "lock pulse");
    rd_all();
    chk(lock === 1'b0, "lock stuck");
    $display("test loads done");
    for (int k = 0; k < REG_COUNT; k++) begin
      w = (k == 0) ? 32'h00000000 : (nxt() >> (k * 3));
      ext_m[k] = flt(w);
      issue(OP_FLOAT, k[2:0], {8'h00, w}, 1'b1);
    end
    rd_all();
    $display("test float done");
    // Normal idle, an ignored load while waiting, prompt interrupt
    issue(OP_IDLE, 3'h0, 40'h0000000000, 1'b1);
    chk(rdy === 1'b0 && crun === 1'b1, "idle");
    issue(OP_LOAD_FP_VALUE, 3'h1, 40'h123456789a, 1'b0);
    wake(8'h00);
    ack();
    rd_all();
    // Low-power wait with a slow interrupt
    issue(OP_LOW_POWER_WAIT, 3'h0, 40'h0000000000, 1'b1);
    chk(rdy === 1'b0 && crun === 1'b0, "clock stop");
    repeat (5) @(negedge clk);
    chk(crun === 1'b0, "clock restarted early");
    wake(8'h28);
    ack();
    $display("test idle done");
    lastv = 5'h00;
    for (int t = 0; t < 32; t++) begin
      tvec = t[4:0];
      issue(OP_TRAP, 3'h0, 40'h0000000000, 1'b1);
      if (t <= 27) lastv = t[4:0];
      chk(ttk === (t <= 27) && tbad === (t > 27), "trap");
      chk(ovec === lastv, "trap vector");
    end
    rd_all();
    // Let the watcher take the last notes before the verdict
    @(negedge clk);
    chk(q.size() == 0, "notes left unread");
    $display("test trap done");
    report_and_stop();
  end
endmodule
`default_nettype wire
